// ==== rtl/fswd_params.svh ====
`ifndef FSWD_PARAMS_SVH
`define FSWD_PARAMS_SVH

// ----------------------------------------------------------------------
// Prescaler and counter width
// ----------------------------------------------------------------------
`define FSWD_DIV_SLOW       16384
`define FSWD_DIV_FAST       256
`define FSWD_COUNT_WIDTH    16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define FSWD_RESET_RELOAD   16'hFF00
`define FSWD_RESET_DIV_SLOW 1'h0
`define FSWD_RESET_ENABLED  1'h1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FSWD_CLK_PERIOD_NS  4
`define FSWD_PREWARN_NS     128
`define FSWD_PREWARN_CYCLES \
    ((`FSWD_PREWARN_NS + `FSWD_CLK_PERIOD_NS - 1) / `FSWD_CLK_PERIOD_NS)

`endif

// ==== rtl/fswd_pkg.sv ====
package fswd_pkg;

    typedef enum logic [1:0] {
        fswd_st_watch,
        fswd_st_warn,
        fswd_st_reset
    } fswd_state_type;

    typedef logic [15:0] fswd_count_type;

endpackage : fswd_pkg

// ==== rtl/fswd_presc_if.sv ====
`timescale 1ns/100ps

interface fswd_presc_if;
    logic run;
    logic clear;
    logic div_slow;
    logic tick;

    modport ctl (output run, output clear, output div_slow, input tick);
    modport pre (input run, input clear, input div_slow, output tick);
endinterface : fswd_presc_if

// ==== rtl/fswd_prescaler.sv ====
`timescale 1ns/100ps
`include "fswd_params.svh"

module fswd_prescaler #(
    parameter int DIV_SLOW = `FSWD_DIV_SLOW,
    parameter int DIV_FAST = `FSWD_DIV_FAST
) (
    input  wire logic  core_clk,
    input  wire logic  srst,
    fswd_presc_if.pre  ps
);
    import fswd_pkg::*;

    localparam int W  = $clog2(DIV_SLOW);
    localparam int FW = $clog2(DIV_FAST);

    generate
        if (DIV_FAST < 2 || DIV_FAST >= DIV_SLOW || (1 << W) != DIV_SLOW
            || (1 << FW) != DIV_FAST) begin : g_bad_div
            $error("fswd_prescaler: dividers must be powers of two, fast below slow");
        end
    endgenerate

    logic [W-1:0] cnt;

    // ----------------------------------------------------------------------
    // Divider chain
    // ----------------------------------------------------------------------
    // Fast mode taps the low bits, so switching ratio never needs a reload
    assign ps.tick = ps.run && !ps.clear && (ps.div_slow ? (&cnt) : (&cnt[FW-1:0]));

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt <= '0;
        end else if (ps.clear) begin
            cnt <= '0;
        end else if (ps.run) begin
            cnt <= cnt + 1'b1;
        end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    presc_clear_a: assert property (ps.clear |=> cnt == '0)
        else $error("prescaler not cleared by service");
    presc_frozen_a: assert property (!ps.run && !ps.clear |-> !ps.tick ##1 $stable(cnt))
        else $error("prescaler moved while stopped");
    presc_fast_a: assert property (ps.tick && !ps.div_slow |-> cnt[FW-1:0] == '1 && ps.run)
        else $error("fast tick off its divide point");

endmodule : fswd_prescaler

// ==== rtl/fswd_watchdog.sv ====
`timescale 1ns/100ps
`include "fswd_params.svh"

module fswd_watchdog #(
    parameter int                    COUNT_WIDTH    = `FSWD_COUNT_WIDTH,
    parameter int                    PREWARN_DELAY  = `FSWD_PREWARN_CYCLES,
    parameter logic [COUNT_WIDTH-1:0] DEFAULT_RELOAD = `FSWD_RESET_RELOAD
) (
    input  wire logic                   core_clk,
    input  wire logic                   srst,
    input  wire logic                   watchdog_service_instruction,
    input  wire logic                   watchdog_off_instruction,
    input  wire logic                   watchdog_on_instruction,
    input  wire logic                   config_write,
    input  wire logic [COUNT_WIDTH-1:0] watchdog_reload_value,
    input  wire logic                   prescale_slow,
    output logic                        prewarn_irq,
    output logic                        reset_request,
    output logic                        watchdog_enabled,
    output logic [COUNT_WIDTH-1:0]      watchdog_count,
    output fswd_pkg::fswd_state_type    watchdog_state
);
    import fswd_pkg::*;

    localparam int WW = (PREWARN_DELAY < 2) ? 1 : $clog2(PREWARN_DELAY);
    localparam logic [WW-1:0] WARN_LAST = WW'(PREWARN_DELAY - 1);
    localparam int PW_GAP = PREWARN_DELAY;

    generate
        if (COUNT_WIDTH < 8 || COUNT_WIDTH > 32 || PREWARN_DELAY < 1
            || PREWARN_DELAY > 4096) begin : g_bad_param
            $error("fswd_watchdog: unsupported width or prewarning delay");
        end
    endgenerate

    fswd_presc_if ps_bus ();

    logic                   div_slow;
    logic [COUNT_WIDTH-1:0] reload;
    logic [WW-1:0]          warn_cnt;
    logic                   service;
    logic                   overflow;
    logic                   warn_done;
    fswd_state_type         next_state;

    fswd_prescaler #(
        .DIV_SLOW (`FSWD_DIV_SLOW),
        .DIV_FAST (`FSWD_DIV_FAST)
    ) u_prescaler (
        .core_clk (core_clk),
        .srst     (srst),
        .ps       (ps_bus.pre)
    );

    // ----------------------------------------------------------------------
    // Instruction decode
    // ----------------------------------------------------------------------
    assign service = watchdog_service_instruction;

    // On wins over off in the same cycle: a stuck decoder fails safe
    always_ff @(posedge core_clk) begin
        if (srst) begin
            watchdog_enabled <= `FSWD_RESET_ENABLED;
        end else if (watchdog_on_instruction) begin
            watchdog_enabled <= 1'h1;
        end else if (watchdog_off_instruction) begin
            watchdog_enabled <= 1'h0;
        end
    end

    // ----------------------------------------------------------------------
    // Reload value and prescaler choice
    // ----------------------------------------------------------------------
    // Slow ratio with full reload range gives the longest interval
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reload   <= DEFAULT_RELOAD;
            div_slow <= `FSWD_RESET_DIV_SLOW;
        end else if (config_write) begin
            reload   <= watchdog_reload_value;
            div_slow <= prescale_slow;
        end
    end

    assign ps_bus.run      = watchdog_enabled;
    assign ps_bus.clear    = service;
    assign ps_bus.div_slow = div_slow;

    // ----------------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------------
    assign overflow = watchdog_enabled && ps_bus.tick && !service
                      && (&watchdog_count);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            watchdog_count <= DEFAULT_RELOAD;
        end else if (service) begin
            watchdog_count <= reload;
        end else if (watchdog_enabled && ps_bus.tick) begin
            watchdog_count <= watchdog_count + 1'b1;
        end
    end

    // ----------------------------------------------------------------------
    // Overflow sequence
    // ----------------------------------------------------------------------
    // Service during the prewarning window cancels the reset; a late
    // interrupt handler can still rescue the system
    assign warn_done = watchdog_enabled && !service && (warn_cnt == WARN_LAST);

    always_comb begin
        next_state = watchdog_state;
        case (watchdog_state)
            fswd_st_watch: begin
                if (overflow) begin
                    next_state = fswd_st_warn;
                end
            end
            fswd_st_warn: begin
                if (service) begin
                    next_state = fswd_st_watch;
                end else if (warn_done) begin
                    next_state = fswd_st_reset;
                end
            end
            fswd_st_reset: begin
                next_state = fswd_st_reset;
            end
            default: begin
                next_state = fswd_st_watch;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            watchdog_state <= fswd_st_watch;
        end else begin
            watchdog_state <= next_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            warn_cnt <= '0;
        end else if (watchdog_state != fswd_st_warn) begin
            warn_cnt <= '0;
        end else if (watchdog_enabled && !service && warn_cnt != WARN_LAST) begin
            warn_cnt <= warn_cnt + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            prewarn_irq <= 1'h0;
        end else begin
            prewarn_irq <= (watchdog_state == fswd_st_watch) && overflow;
        end
    end

    // Held until the application reset that it asks for
    always_ff @(posedge core_clk) begin
        if (srst) begin
            reset_request <= 1'h0;
        end else if (watchdog_state == fswd_st_warn && warn_done) begin
            reset_request <= 1'h1;
        end
    end

    // ----------------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_overflow_hit;
        watchdog_enabled && ps_bus.tick && !service && (&watchdog_count);
    endsequence

    sequence s_warn_quiet;
        watchdog_enabled && !service && watchdog_state == fswd_st_warn;
    endsequence

    // Must see reset itself, so the default disable is overridden
    reset_enabled_a: assert property (@(posedge core_clk) disable iff (1'b0)
        srst ##1 !srst |-> watchdog_enabled && watchdog_count == DEFAULT_RELOAD
            && !prewarn_irq && !reset_request)
        else $error("watchdog not armed after reset");

    off_stops_a: assert property (watchdog_off_instruction && !watchdog_on_instruction
        |=> !watchdog_enabled
            ##1 watchdog_enabled == $past(watchdog_on_instruction))
        else $error("off instruction did not stop watchdog");

    on_starts_a: assert property (watchdog_on_instruction |=> watchdog_enabled)
        else $error("on instruction did not start watchdog");

    service_reload_a: assert property (service |=> watchdog_count == $past(reload)
        && !prewarn_irq)
        else $error("service did not reload counter");

    count_step_a: assert property (watchdog_enabled && ps_bus.tick && !service
        && !(&watchdog_count) |=> watchdog_count == $past(watchdog_count) + 1'b1)
        else $error("counter did not advance on tick");

    overflow_wrap_a: assert property (s_overflow_hit and watchdog_state == fswd_st_watch
        |=> watchdog_count == '0 && prewarn_irq)
        else $error("overflow did not wrap and prewarn");

    prewarn_order_a: assert property (prewarn_irq |-> !reset_request
        ##1 !prewarn_irq)
        else $error("reset request came before prewarning");

    reset_timing_a: assert property ($rose(reset_request) |->
        $past(watchdog_state == fswd_st_warn) && $past(warn_cnt) == WARN_LAST)
        else $error("reset request without full prewarning delay");

    reset_gap_a: assert property (prewarn_irq ##0 s_warn_quiet
        |-> ##[1:PW_GAP] (reset_request || !watchdog_enabled || service))
        else $error("reset request missing after prewarning");

    disabled_frozen_a: assert property (!watchdog_enabled && !service
        |=> $stable(watchdog_count) && !prewarn_irq)
        else $error("disabled watchdog moved");

    disabled_quiet_a: assert property (!watchdog_enabled
        |=> !$rose(reset_request))
        else $error("disabled watchdog requested reset");

    default_interval_a: assert property (@(posedge core_clk) disable iff (1'b0) srst ##1 !srst |->
        reload == DEFAULT_RELOAD && div_slow == `FSWD_RESET_DIV_SLOW)
        else $error("power-up interval settings wrong");

endmodule : fswd_watchdog

// ==== testbench/fswd_watchdog_test.sv ====
`timescale 1ns/100ps

module fswd_watchdog_test;
    import fswd_pkg::*;

    localparam int DLY   = 2;
    localparam int LIMIT = 99000;

    logic                 core_clk = 1'b0;
    logic                 srst     = 1'b1;
    logic                 svc      = 1'b0;
    logic                 off      = 1'b0;
    logic                 on       = 1'b0;
    logic                 cfg      = 1'b0;
    logic [15:0]          rel      = 16'h0000;
    logic                 slow     = 1'b0;
    logic                 prewarn_irq;
    logic                 reset_request;
    logic                 watchdog_enabled;
    logic [15:0]          watchdog_count;
    fswd_state_type       watchdog_state;
    int                   bad_count = 0;
    int                   checked   = 0;
    int                   cycles    = 0;
    int                   warns     = 0;
    int                   n;
    int                   w;
    logic [15:0]          r;
    logic [15:0]          c;

    fswd_watchdog #(.PREWARN_DELAY(DLY)) uut (
        .core_clk                     (core_clk),
        .srst                         (srst),
        .watchdog_service_instruction (svc),
        .watchdog_off_instruction     (off),
        .watchdog_on_instruction      (on),
        .config_write                 (cfg),
        .watchdog_reload_value        (rel),
        .prescale_slow                (slow),
        .prewarn_irq                  (prewarn_irq),
        .reset_request                (reset_request),
        .watchdog_enabled             (watchdog_enabled),
        .watchdog_count               (watchdog_count),
        .watchdog_state               (watchdog_state)
    );

    always #2 core_clk = ~core_clk;

    // ------------------------------------------------------------------
    // Cut a hang short
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (prewarn_irq === 1'b1) begin
            warns <= warns + 1;
        end
        if (cycles == LIMIT) begin
            bad_count = bad_count + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : check_eq

    task automatic check_near(input int got, input int exp, input int tol);
        checked = checked + 1;
        if (got < exp - tol || got > exp + tol) begin
            bad_count = bad_count + 1;
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : check_near

    // Bits: service, off, on; held for exactly one rising edge
    task automatic strobe(input logic [2:0] s);
        @(negedge core_clk);
        {svc, off, on} = s;
        @(negedge core_clk);
        {svc, off, on} = 3'b000;
    endtask : strobe

    task automatic config_set(input logic [15:0] v, input logic s);
        @(negedge core_clk);
        cfg  = 1'b1;
        rel  = v;
        slow = s;
        @(negedge core_clk);
        cfg  = 1'b0;
    endtask : config_set

    task automatic wait_warn(output int k);
        k = 0;
        while (prewarn_irq !== 1'b1 && k < 70000) begin
            @(posedge core_clk);
            #1;
            k = k + 1;
        end
    endtask : wait_warn

    task automatic do_reset();
        @(negedge core_clk);
        srst = 1'b1;
        repeat (4) @(negedge core_clk);
        srst = 1'b0;
    endtask : do_reset

    initial begin
        void'($urandom(78660));
        repeat (16) @(negedge core_clk);
        srst = 1'b0;
        check_eq(watchdog_enabled, 1'b1);
        check_eq(watchdog_count, 16'hFF00);
        check_eq({prewarn_irq, reset_request}, 2'b00);
        // Untouched after reset: default interval to overflow
        wait_warn(n);
        check_near(n, 65536, 2);
        check_eq(watchdog_count, 16'h0000);
        check_eq(watchdog_state, fswd_st_warn);
        repeat (DLY - 1) @(posedge core_clk);
        #1;
        check_eq({prewarn_irq, reset_request}, 2'b00);
        @(posedge core_clk);
        #1;
        check_eq(reset_request, 1'b1);
        do_reset();
        // Random reloads near the top, serviced just after each prewarning
        repeat (3) begin
            r = 16'hFFFF - 16'($urandom % 3);
            config_set(r, 1'b0);
            strobe(3'b100);
            check_eq(watchdog_count, r);
            wait_warn(n);
            check_near(n, (65536 - int'(r)) * 256, 2);
            strobe(3'b100);
            check_eq(watchdog_state, fswd_st_watch);
            repeat (8) @(negedge core_clk);
            check_eq(reset_request, 1'b0);
        end
        // Second service in mid-count clears the prescaler
        config_set(16'h1234, 1'b0);
        strobe(3'b100);
        repeat (200) @(negedge core_clk);
        strobe(3'b100);
        repeat (250) @(negedge core_clk);
        check_eq(watchdog_count, 16'h1234);
        repeat (10) @(negedge core_clk);
        check_eq(watchdog_count, 16'h1235);
        // Slow divider
        config_set(16'h1234, 1'b1);
        strobe(3'b100);
        repeat (16300) @(negedge core_clk);
        check_eq(watchdog_count, 16'h1234);
        repeat (100) @(negedge core_clk);
        check_eq(watchdog_count, 16'h1235);
        // Disabled at the brink of overflow: frozen and silent
        config_set(16'hFFFF, 1'b0);
        strobe(3'b100);
        strobe(3'b010);
        check_eq(watchdog_enabled, 1'b0);
        c = watchdog_count;
        w = warns;
        repeat (600) @(negedge core_clk);
        check_eq(watchdog_count, c);
        check_eq(warns - w, 0);
        strobe(3'b011);
        check_eq(watchdog_enabled, 1'b1);
        wait_warn(n);
        // Prescaler resumes from the 2 it was frozen at
        check_near(n, 256 - 2, 0);
        // Pause the prewarning delay, resume, then service in reset state
        strobe(3'b010);
        check_eq(watchdog_enabled, 1'b0);
        repeat (20) @(negedge core_clk);
        check_eq(watchdog_state, fswd_st_warn);
        check_eq(reset_request, 1'b0);
        strobe(3'b001);
        check_eq(watchdog_enabled, 1'b1);
        repeat (DLY) @(negedge core_clk);
        check_eq(reset_request, 1'b1);
        check_eq(watchdog_state, fswd_st_reset);
        strobe(3'b100);
        check_eq(watchdog_count, 16'hFFFF);
        w = warns;
        repeat (300) @(negedge core_clk);
        check_eq(watchdog_count, 16'h0000);
        check_eq(warns - w, 0);
        check_eq(reset_request, 1'b1);
        tally_and_finish();
    end
endmodule : fswd_watchdog_test
